// ===== rtl/regulator_enable_control_defs.svh
`ifndef REGULATOR_ENABLE_CONTROL_DEFS_SVH
`define REGULATOR_ENABLE_CONTROL_DEFS_SVH

// system clock rate
`define CLK_MHZ           50
// short and overload debounce time
`define SHORT_TIME_US     1000
`define SHORT_CYCLES      (`SHORT_TIME_US * `CLK_MHZ)
// time of one step of a delay code
`define DELAY_STEP_US     500
`define DELAY_STEP_CYCLES (`DELAY_STEP_US * `CLK_MHZ)

// register byte offsets
`define ADDR_CTRL         8'h00
`define ADDR_RAIL         8'h04
`define ADDR_DELAY        8'h08
`define ADDR_VOLT         8'h0C
`define ADDR_FLAGS        8'h10
`define ADDR_MASK         8'h14
`define ADDR_STATUS       8'h18

// control register fields
`define CTRL_EXT_CLK      0
`define CTRL_BUCK_WIN     1
`define CTRL_LIN_WIN      2
`define CTRL_PULLDOWN     3
`define CTRL_RESET        4'h0

// flag and mask fields
`define FLAG_SHORT        0
`define FLAG_GOOD         4
`define FLAG_CLK          8
`define MASK_RISE         0
`define MASK_FALL         4
`define MASK_RESET        8'h00

`endif

// ===== rtl/regulator_enable_control_pkg.sv
package regulator_enable_control_pkg;

    // device operating state
    typedef enum logic [1:0] {
        ST_LOAD,
        ST_STANDBY,
        ST_ACTIVE
    } pwr_state_e;

    // one bit per rail: buck0, buck1, linreg0, linreg1
    typedef logic [3:0] rail_vec_t;

endpackage : regulator_enable_control_pkg

// ===== rtl/rail_channel.sv
`timescale 1ns/1ns
`default_nettype none

module rail_channel #(
    parameter int unsigned SHORT_CYCLES = 50000
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       tick,
    input  wire logic       allow,
    input  wire logic       pin_level,
    input  wire logic       on_bit,
    input  wire logic       pin_gate,
    input  wire logic       above_min,
    input  wire logic [3:0] on_code,
    input  wire logic [3:0] off_code,
    output logic            enable_q,
    output logic            ramp_q,
    output logic            short_pulse_q
);

    localparam logic [15:0] SC_LAST = 16'(SHORT_CYCLES - 1);

    logic        pin_on_q;   // delayed pin level
    logic [3:0]  dly_q;      // delay steps counted
    logic [15:0] sc_q;       // cycles spent below minimum
    logic        tripped_q;  // held off after a short
    logic        req;        // requested on
    logic        trip;       // short detected now

    // register path is immediate, pin path uses the delayed level
    assign req  = allow & on_bit & (~pin_gate | pin_on_q); // [R4] [R5] [R8]
    assign trip = enable_q & ~above_min & (sc_q == SC_LAST);

    // pin delay; a return to the old level cancels the count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_on_q <= 1'b0;
            dly_q    <= 4'h0;
        end else if (pin_level == pin_on_q) begin
            dly_q <= 4'h0; // [R18]
        end else if (dly_q >= (pin_level ? on_code : off_code)) begin
            pin_on_q <= pin_level; // [R7]
            dly_q    <= 4'h0;
        end else if (tick) begin
            dly_q <= dly_q + 4'h1;
        end
    end

    // below-minimum timer, covers start-up and running overload
    always_ff @(posedge sys_clk) begin
        if (reset || !enable_q || above_min) begin
            sc_q <= 16'h0000;
        end else begin
            sc_q <= sc_q + 16'h0001; // [R10] [R11]
        end
    end

    // a trip holds the rail off until the request drops, by its bit or by a gated pin
    always_ff @(posedge sys_clk) begin
        if (reset || !req) begin
            tripped_q <= 1'b0;
        end else if (trip) begin
            tripped_q <= 1'b1; // [R10] [R11]
        end
    end

    // rail enable and short event
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enable_q      <= 1'b0;
            short_pulse_q <= 1'b0;
        end else begin
            enable_q      <= req & ~tripped_q & ~trip; // [R5] [R6]
            short_pulse_q <= trip; // [R10] [R11]
        end
    end

    // soft start ends once the output passes the minimum
    always_ff @(posedge sys_clk) begin
        if (reset || !enable_q) begin
            ramp_q <= 1'b0;
        end else if (above_min) begin
            ramp_q <= 1'b1; // [R9]
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_trip;
        trip ##1 (!enable_q && short_pulse_q);
    endsequence

    chk_short_off: assert property (trip |-> s_trip) // [R10]
        else $error("short did not disable the rail");
    chk_bit_off: assert property (!on_bit |=> !enable_q) // [R5]
        else $error("rail on with its enable bit clear");
    chk_reg_direct: assert property (
        (req && !pin_gate && !tripped_q && !trip) |=> enable_q) // [R8]
        else $error("register enable was delayed");
    chk_pin_follow: assert property (
        $changed(pin_on_q) |-> pin_on_q == $past(pin_level)) // [R7]
        else $error("delayed level differs from pin");
    chk_cancel_hold: assert property (
        (pin_level == pin_on_q) |=> $stable(pin_on_q)) // [R18]
        else $error("cancelled delay still switched");

endmodule : rail_channel

`default_nettype wire

// ===== rtl/regulator_enable_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "regulator_enable_control_defs.svh"

// Behaviour
// [R1] clock select gates detector, switch, clock flag
// [R2] host waits 1.2 ms before bus access
// [R3] power-on loads defaults then enters standby
// [R4] enables accepted only in standby or active
// [R5] buck follows bit, or pin when gated
// [R6] linreg uses the same two methods
// [R7] pin edges wait on and off delays
// [R8] register enables act without delay
// [R9] buck leaves soft start above minimum
// [R10] buck short or overload disables, flags
// [R11] linreg short or overload disables, flags
// [R12] valid output sets good flag unless masked
// [R13] invalid output sets good flag unless masked
// [R14] live good state per rail
// [R15] window select per rail group
// [R16] pulldown on enable pin by config bit
// [R17] irq low while any flag pending
// [R18] delay step mapping parameter, cancel on return
module regulator_enable_control
    import regulator_enable_control_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = `SHORT_CYCLES,
    parameter int unsigned STEP_CYCLES  = `DELAY_STEP_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        en_pin,
    input  wire logic        sync_clock_present,
    input  wire logic [3:0]  rail_above_min,
    input  wire logic [3:0]  rail_uv_ok,
    input  wire logic [3:0]  rail_ov_ok,
    input  wire logic [7:0]  otp_rail_bits,
    input  wire logic [31:0] otp_delays,
    output logic [1:0]       buck_enable,
    output logic [1:0]       linreg_enable,
    output logic [1:0]       buck_ramp_mode,
    output logic [15:0]      buck_target_voltage,
    output logic [9:0]       linreg_target_voltage,
    output logic             clk_detect_enable,
    output logic             use_ext_clock,
    output logic             enable_input_pulldown_on,
    output logic             irq_out_low
);

    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

    // bus slave state
    logic        wr_q;        // write data phase pending
    logic        rd_q;        // read data phase pending
    logic [7:0]  addr_q;      // captured byte offset
    logic        ready_q;     // hreadyout register
    logic        resp_q;      // always okay
    logic [31:0] rdata_q;     // read data register
    logic [31:0] rd_word;     // read mux
    logic        ap_take;     // address phase accepted
    logic        we;          // register write strobe

    // software registers
    logic [3:0]  ctrl_q;      // clock select, windows, pulldown
    logic [7:0]  rail_q;      // on bits [3:0], pin gates [7:4]
    logic [31:0] delay_q;     // per rail: on [3:0], off [7:4]
    logic [15:0] buck_volt_q; // buck target codes
    logic [9:0]  lin_volt_q;  // linreg target codes
    logic [8:0]  flags_q;     // short, good, clock flags
    logic [8:0]  flag_set;    // hardware events
    logic [8:0]  flag_clr;    // write-one-to-clear
    logic [7:0]  mask_q;      // good rise [3:0], fall [7:4]

    // device state
    pwr_state_e  state_q;
    logic        allow;       // rail requests accepted

    // synchronisers for pins and analog comparators
    logic [13:0] meta_q;
    logic [13:0] sync_q;
    logic        en_s;
    logic        clk_s;
    rail_vec_t   above_s;
    rail_vec_t   uv_s;
    rail_vec_t   ov_s;

    // clock monitor
    logic        clk_prev_q;  // last seen presence
    logic        clk_det_q;   // detector enable register
    logic        use_ext_q;   // external clock in use
    logic        clk_evt;     // presence changed

    // delay step divider
    logic [15:0] step_cnt_q;
    logic        tick_q;

    // rail outputs and good detection
    rail_vec_t   rail_en_w;
    rail_vec_t   ramp_w;
    rail_vec_t   short_w;
    rail_vec_t   win_sel;
    rail_vec_t   valid;
    rail_vec_t   good_q;
    rail_vec_t   rise;
    rail_vec_t   fall;
    logic        irq_low_q;
    logic        pulldown_q;

    // the host is told to wait after power-up; nothing here
    // depends on it, the bus simply stalls during the load
    assign ap_take  = hsel & htrans[1] & hready; // [R2]
    assign we       = wr_q;
    assign allow    = (state_q != ST_LOAD); // [R4]

    assign en_s    = sync_q[13];
    assign clk_s   = sync_q[12];
    assign above_s = sync_q[11:8];
    assign uv_s    = sync_q[7:4];
    assign ov_s    = sync_q[3:0];

    // two-stage synchroniser, first stage read by second only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_q <= 14'h0000;
            sync_q <= 14'h0000;
        end else begin
            meta_q <= {en_pin, sync_clock_present, rail_above_min,
                       rail_uv_ok, rail_ov_ok};
            sync_q <= meta_q;
        end
    end

    // address phase capture, held while a read waits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_q <= ap_take & hwrite;
            rd_q <= ap_take & ~hwrite;
            if (ap_take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // one wait state on reads; stalled while defaults load
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ready_q <= 1'b0;
            resp_q  <= 1'b0;
        end else begin
            ready_q <= allow & ~(ap_take & ~hwrite); // [R3]
            resp_q  <= 1'b0;
        end
    end

    // read data loads in the wait cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_q && !ready_q) begin
            rdata_q <= rd_word;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            `ADDR_CTRL:   rd_word[3:0] = ctrl_q;
            `ADDR_RAIL:   rd_word[7:0] = rail_q;
            `ADDR_DELAY:  rd_word      = delay_q;
            `ADDR_VOLT: begin
                rd_word = {3'h0, lin_volt_q[9:5], 3'h0,
                           lin_volt_q[4:0], buck_volt_q};
            end
            `ADDR_FLAGS:  rd_word[8:0] = flags_q;
            `ADDR_MASK:   rd_word[7:0] = mask_q;
            `ADDR_STATUS: begin
                rd_word[10:0] = {2'(state_q), use_ext_q,
                                 rail_en_w, good_q}; // [R14]
            end
            default:      rd_word = 32'h0000_0000;
        endcase
    end

    // control register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET;
        end else if (we && addr_q == `ADDR_CTRL) begin
            ctrl_q <= hwdata[3:0];
        end
    end

    // rail bits and delays: defaults from fuses, then software
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rail_q  <= 8'h00;
            delay_q <= 32'h0000_0000;
        end else if (state_q == ST_LOAD) begin
            rail_q  <= otp_rail_bits; // [R3]
            delay_q <= otp_delays;
        end else begin
            if (we && addr_q == `ADDR_RAIL) begin
                rail_q <= hwdata[7:0];
            end
            if (we && addr_q == `ADDR_DELAY) begin
                delay_q <= hwdata;
            end
        end
    end

    // target voltage codes
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            buck_volt_q <= 16'h0000;
            lin_volt_q  <= 10'h000;
        end else if (we && addr_q == `ADDR_VOLT) begin
            buck_volt_q <= hwdata[15:0];
            lin_volt_q  <= {hwdata[28:24], hwdata[20:16]};
        end
    end

    // good masks
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_q <= `MASK_RESET;
        end else if (we && addr_q == `ADDR_MASK) begin
            mask_q <= hwdata[7:0];
        end
    end

    // operating state
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= ST_LOAD;
        end else begin
            case (state_q)
                ST_LOAD: begin
                    state_q <= ST_STANDBY; // [R3]
                end
                ST_STANDBY: begin
                    if (rail_en_w != 4'h0) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (rail_en_w == 4'h0) begin
                        state_q <= ST_STANDBY;
                    end
                end
                default: begin
                    state_q <= ST_LOAD;
                end
            endcase
        end
    end

    // delay step divider, one-cycle tick
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            step_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else if (step_cnt_q == STEP_LAST) begin
            step_cnt_q <= 16'h0000;
            tick_q     <= 1'b1; // [R18]
        end else begin
            step_cnt_q <= step_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // one channel per rail, bucks first then linregs
    for (genvar i = 0; i < 4; i++) begin : g_rail
        rail_channel #(
            .SHORT_CYCLES (SHORT_CYCLES)
        ) u_rail (
            .sys_clk       (sys_clk),
            .reset         (reset),
            .tick          (tick_q),
            .allow         (allow),
            .pin_level     (en_s),
            .on_bit        (rail_q[i]),
            .pin_gate      (rail_q[i+4]),
            .above_min     (above_s[i]),
            .on_code       (delay_q[8*i +: 4]),
            .off_code      (delay_q[8*i+4 +: 4]),
            .enable_q      (rail_en_w[i]), // [R5] [R6]
            .ramp_q        (ramp_w[i]),
            .short_pulse_q (short_w[i])
        );
    end

    // clock detector and source switch
    assign clk_evt = ctrl_q[`CTRL_EXT_CLK] & (clk_s != clk_prev_q);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clk_prev_q <= 1'b0;
            clk_det_q  <= 1'b0;
            use_ext_q  <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            clk_det_q  <= ctrl_q[`CTRL_EXT_CLK]; // [R1]
            use_ext_q  <= ctrl_q[`CTRL_EXT_CLK] & clk_s; // [R1]
        end
    end

    // validity: undervoltage only, or both when window bit set
    assign win_sel = {{2{ctrl_q[`CTRL_LIN_WIN]}},
                      {2{ctrl_q[`CTRL_BUCK_WIN]}}};
    assign valid   = rail_en_w & uv_s & (ov_s | ~win_sel); // [R15]
    assign rise    = valid & ~good_q;
    assign fall    = ~valid & good_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            good_q <= 4'h0;
        end else begin
            good_q <= valid; // [R14]
        end
    end

    // sticky flags, a set in the clearing cycle wins
    assign flag_set[`FLAG_SHORT +: 4] = short_w; // [R10] [R11]
    assign flag_set[`FLAG_GOOD +: 4] =
        (rise & ~mask_q[`MASK_RISE +: 4]) | // [R12]
        (fall & ~mask_q[`MASK_FALL +: 4]); // [R13]
    assign flag_set[`FLAG_CLK] = clk_evt; // [R1]
    assign flag_clr = (we && addr_q == `ADDR_FLAGS) ? hwdata[8:0]
                                                    : 9'h000;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            flags_q <= 9'h000;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // interrupt line and pulldown control
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_low_q  <= 1'b1;
            pulldown_q <= 1'b0;
        end else begin
            irq_low_q  <= (flags_q == 9'h000); // [R17]
            pulldown_q <= ctrl_q[`CTRL_PULLDOWN]; // [R16]
        end
    end

    assign hreadyout                = ready_q;
    assign hresp                    = resp_q;
    assign hrdata                   = rdata_q;
    assign buck_enable              = rail_en_w[1:0];
    assign linreg_enable            = rail_en_w[3:2];
    assign buck_ramp_mode           = ramp_w[1:0];
    assign buck_target_voltage      = buck_volt_q;
    assign linreg_target_voltage    = lin_volt_q;
    assign clk_detect_enable        = clk_det_q;
    assign use_ext_clock            = use_ext_q;
    assign enable_input_pulldown_on = pulldown_q;
    assign irq_out_low              = irq_low_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_boot;
        (state_q == ST_LOAD) ##1
        (state_q == ST_STANDBY && rail_q == $past(otp_rail_bits));
    endsequence

    chk_boot_load: assert property ((state_q == ST_LOAD) |-> s_boot) // [R3]
        else $error("defaults not loaded before standby");
    chk_load_gate: assert property (
        (state_q == ST_LOAD) |=> rail_en_w == 4'h0) // [R4]
        else $error("rail enabled during load");
    chk_clk_off: assert property (
        !ctrl_q[`CTRL_EXT_CLK] |=> (!use_ext_q && !clk_det_q)) // [R1]
        else $error("external clock used while deselected");
    chk_clk_flag: assert property (clk_evt |=> flags_q[`FLAG_CLK]) // [R1]
        else $error("clock change not flagged");
    chk_good_rise: assert property (
        (rise[0] && !mask_q[`MASK_RISE]) |=> flags_q[`FLAG_GOOD]) // [R12]
        else $error("rising good not flagged");
    chk_good_fall: assert property (
        (fall[0] && !mask_q[`MASK_FALL]) |=> flags_q[`FLAG_GOOD]) // [R13]
        else $error("falling good not flagged");
    chk_win_uv: assert property (
        (rail_en_w[0] && uv_s[0] && !ctrl_q[`CTRL_BUCK_WIN])
        |=> good_q[0]) // [R15]
        else $error("undervoltage-only window ignored");
    chk_irq_level: assert property (
        (flags_q != 9'h000) |=> !irq_out_low) // [R17]
        else $error("irq released with flags pending");

endmodule : regulator_enable_control

`default_nettype wire

// ===== tb/rail_model.sv
`timescale 1ns/1ns
`default_nettype none

// analog side of the four rails: output ramps a few cycles after enable
module rail_model (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [3:0] rail_on,
    input  wire logic [3:0] short_req,
    input  wire logic [3:0] ov_bad,
    output logic      [3:0] rail_above_min,
    output logic      [3:0] rail_uv_ok,
    output logic      [3:0] rail_ov_ok
);
    logic [3:0] ramp_q; // first ramp stage per rail

    // shorted rails never climb past the minimum level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ramp_q         <= 4'h0;
            rail_above_min <= 4'h0;
            rail_uv_ok     <= 4'h0;
        end else begin
            ramp_q         <= rail_on & ~short_req;
            rail_above_min <= ramp_q & ~short_req;
            rail_uv_ok     <= rail_above_min & ~short_req;
        end
    end

    // overvoltage detector, driven bad only when asked
    assign rail_ov_ok = ~ov_bad;
endmodule : rail_model

`default_nettype wire

// ===== tb/tb_regulator_enable_control.sv
`timescale 1ns/1ns
`default_nettype none

module tb_regulator_enable_control;
    logic        sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, otp_delays, r, volt;
    logic [1:0]  htrans, buck_enable, linreg_enable, buck_ramp_mode;
    logic [2:0]  hsize;
    logic [3:0]  rail_above_min, rail_uv_ok, rail_ov_ok, short_req, ov_bad;
    logic [3:0]  oc, fc;
    logic [7:0]  otp_rail_bits;
    logic [15:0] buck_target_voltage;
    logic [9:0]  linreg_target_voltage;
    logic        en_pin, sync_clock_present, clk_detect_enable;
    logic        use_ext_clock, enable_input_pulldown_on, irq_out_low;
    int          n_errors, cmp_count;

    assign hready = hreadyout;

    regulator_enable_control #(.SHORT_CYCLES(20), .STEP_CYCLES(8)) i_dut (
        .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .en_pin, .sync_clock_present,
        .rail_above_min, .rail_uv_ok, .rail_ov_ok, .otp_rail_bits,
        .otp_delays, .buck_enable, .linreg_enable, .buck_ramp_mode,
        .buck_target_voltage, .linreg_target_voltage, .clk_detect_enable,
        .use_ext_clock, .enable_input_pulldown_on, .irq_out_low
    );

    rail_model i_rail (
        .sys_clk, .reset, .rail_on({linreg_enable, buck_enable}),
        .short_req, .ov_bad, .rail_above_min, .rail_uv_ok, .rail_ov_ok
    );

    // free-running clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // one single-word bus transfer, waits on the slave's ready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        check($sformatf("reg %h", a), r & m, e);
        check("hresp", 32'(hresp), 32'h0000_0000);
    endtask : rdc

    // linreg codes as they sit on the target voltage output
    function automatic logic [31:0] lin_code(input logic [31:0] v);
        return 32'({v[28:24], v[20:16]});
    endfunction : lin_code

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // hang guard
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        void'($urandom(77469));
        oc = 4'($urandom_range(3, 1));
        fc = 4'($urandom_range(3, 2));
        volt = $urandom & 32'h1F1F_FFFF;
        otp_delays = $urandom;
        otp_rail_bits = 8'h00;
        reset = 1'b1;
        hsel = 1'b1;
        hsize = 3'b010;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        en_pin = 1'b0;
        sync_clock_present = 1'b0;
        short_req = 4'h0;
        ov_bad = 4'h0;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (60000) @(posedge sys_clk); // host start-up wait
        rdc(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rdc(8'h08, 32'hFFFF_FFFF, otp_delays);
        rdc(8'h18, 32'h0000_0600, 32'h0000_0200);
        rdc(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
        xfer(1'b1, 8'h0C, volt);
        rdc(8'h0C, 32'hFFFF_FFFF, volt);
        // register enables: buck0 and linreg1, linreg1 rise masked
        xfer(1'b1, 8'h14, 32'h0000_0008);
        xfer(1'b1, 8'h04, 32'h0000_0009);
        repeat (2) @(posedge sys_clk);
        check("rails", 32'({linreg_enable, buck_enable}),
              32'h0000_0009);
        check("bvset", 32'(buck_target_voltage), volt & 32'h0000_FFFF);
        check("lvset", 32'(linreg_target_voltage), lin_code(volt));
        repeat (8) @(posedge sys_clk);
        check("ramp", 32'(buck_ramp_mode), 32'h0000_0001);
        rdc(8'h10, 32'h0000_00F0, 32'h0000_0010);
        rdc(8'h18, 32'h0000_060F, 32'h0000_0409);
        check("irq", 32'(irq_out_low), 32'h0000_0000);
        // window choice with overvoltage on buck0 and linreg1
        xfer(1'b1, 8'h10, 32'h0000_01FF);
        ov_bad <= 4'h9;
        repeat (6) @(posedge sys_clk);
        rdc(8'h18, 32'h0000_0009, 32'h0000_0009);
        xfer(1'b1, 8'h00, 32'h0000_0006);
        repeat (6) @(posedge sys_clk);
        rdc(8'h18, 32'h0000_0009, 32'h0000_0000);
        rdc(8'h10, 32'h0000_00F0, 32'h0000_0090);
        ov_bad <= 4'h0;
        repeat (6) @(posedge sys_clk);
        xfer(1'b1, 8'h10, 32'h0000_01FF);
        repeat (3) @(posedge sys_clk);
        check("irq", 32'(irq_out_low), 32'h0000_0001);
        // linreg0 under pin control with random delay codes
        xfer(1'b1, 8'h08,
             (otp_delays & 32'hFF00_FFFF) | {8'h00, fc, oc, 16'h0000});
        xfer(1'b1, 8'h04, 32'h0000_004D);
        repeat (3) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0002);
        en_pin <= 1'b1;
        // free-running step tick: a delay may end up to one step early
        repeat (oc * 8 - 3) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0002);
        repeat (14) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0003);
        en_pin <= 1'b0;
        repeat (2) @(posedge sys_clk);
        en_pin <= 1'b1;
        repeat (fc * 8 + 14) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0003);
        en_pin <= 1'b0;
        repeat (fc * 8 - 3) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0003);
        repeat (14) @(posedge sys_clk);
        check("lin", 32'(linreg_enable), 32'h0000_0002);
        // shorts on buck1 at enable and linreg1 in operation
        short_req <= 4'hA;
        xfer(1'b1, 8'h04, 32'h0000_004F);
        repeat (40) @(posedge sys_clk);
        check("rails", 32'({linreg_enable, buck_enable}),
              32'h0000_0001);
        rdc(8'h10, 32'h0000_000F, 32'h0000_000A);
        short_req <= 4'h0;
        // external clock select off, then on with pulldown
        xfer(1'b1, 8'h00, 32'h0000_0000);
        sync_clock_present <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("extclk", 32'(use_ext_clock), 32'h0000_0000);
        rdc(8'h10, 32'h0000_0100, 32'h0000_0000);
        xfer(1'b1, 8'h00, 32'h0000_0009);
        repeat (3) @(posedge sys_clk);
        check("clk", 32'({clk_detect_enable, use_ext_clock}),
              32'h0000_0003);
        check("pd", 32'(enable_input_pulldown_on), 32'h0000_0001);
        sync_clock_present <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rdc(8'h10, 32'h0000_0100, 32'h0000_0100);
        check("extclk", 32'(use_ext_clock), 32'h0000_0000);
        wrap_up();
    end
endmodule : tb_regulator_enable_control

`default_nettype wire
